// File: include/tcs_cfg.svh
// widths, counts, field positions, offsets and reset value of the trigger sequencer
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH

`define TCS_PROBE_W       32
`define TCS_LEVELS        10
`define TCS_LVL_W         4
`define TCS_FIFO_DEPTH    8
`define TCS_SEG_W         4

// register byte offsets
`define TCS_OFF_CTRL      12'h000
`define TCS_OFF_STATUS    12'h004
`define TCS_OFF_LSEL      12'h008
`define TCS_OFF_COND      12'h00C
`define TCS_OFF_MASK      12'h010
`define TCS_OFF_VALUE     12'h014
`define TCS_OFF_EDGE      12'h018
`define TCS_OFF_ADV       12'h01C
`define TCS_OFF_CONST     12'h020
`define TCS_OFF_SAMPLES   12'h024
`define TCS_OFF_DATA      12'h028

// ctrl fields
`define TCS_CTRL_ARM      0
`define TCS_CTRL_EXT_EN   1
`define TCS_CTRL_SEG_EN   2
`define TCS_CTRL_NLVL_LO  4
`define TCS_CTRL_NLVL_HI  7
`define TCS_CTRL_NSEG_LO  8
`define TCS_CTRL_NSEG_HI  11
`define TCS_CTRL_RST      32'h0000_0010

// cond fields: bit 0 advanced select
`define TCS_COND_ADV      0

// adv fields
`define TCS_ADV_CMP_LO    0
`define TCS_ADV_CMP_HI    2
`define TCS_ADV_RED_LO    3
`define TCS_ADV_RED_HI    4
`define TCS_ADV_BW_LO     5
`define TCS_ADV_BW_HI     6
`define TCS_ADV_SHL       7
`define TCS_ADV_SH_LO     8
`define TCS_ADV_SH_HI     12
`define TCS_ADV_LOG_LO    13
`define TCS_ADV_LOG_HI    14
`define TCS_ADV_NOT       15
`define TCS_ADV_EDGE_LO   16
`define TCS_ADV_EDGE_HI   20
`define TCS_ADV_ESEL_LO   21
`define TCS_ADV_ESEL_HI   23

`endif

// File: include/tcs_pkg.sv
// types of the trigger condition sequencer
`default_nettype none
package tcs_pkg;
  `include "tcs_cfg.svh"

  typedef logic [`TCS_PROBE_W-1:0] tcs_word_t;

  // per-signal basic condition, a three-bit code covering level and edge cases
  typedef enum logic [2:0] {
    TCS_BC_IGNORE = 3'h0,
    TCS_BC_LOW    = 3'h1,
    TCS_BC_HIGH   = 3'h2,
    TCS_BC_FALL   = 3'h3,
    TCS_BC_RISE   = 3'h4,
    TCS_BC_ANY    = 3'h5
  } tcs_bcond_t;

  typedef enum logic [2:0] {
    TCS_CMP_LT = 3'h0,
    TCS_CMP_LE = 3'h1,
    TCS_CMP_EQ = 3'h2,
    TCS_CMP_NE = 3'h3,
    TCS_CMP_GT = 3'h4,
    TCS_CMP_GE = 3'h5
  } tcs_cmp_t;

  typedef enum logic [1:0] {
    TCS_ST_IDLE = 2'b00,
    TCS_ST_EXT  = 2'b01,
    TCS_ST_SEQ  = 2'b10,
    TCS_ST_DONE = 2'b11
  } tcs_state_t;
endpackage : tcs_pkg
`default_nettype wire

// File: include/tcs_stream_if.sv
// sample stream between sequencer and capture fifo
`default_nettype none
interface tcs_stream_if;
  import tcs_pkg::*;
  logic      valid;
  logic      ready;
  tcs_word_t data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : tcs_stream_if
`default_nettype wire

// File: logic/tcs_fifo.sv
// capture fifo with valid/ready on both sides
`default_nettype none
module tcs_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } tcs_fifo_st_t;
  tcs_fifo_st_t s_q, s_d;
  logic push, pop;

  // a pop in the same cycle frees a slot, so a full fifo still takes a sample while out_ready is high
  assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH)) || out_ready;
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = mem[s_q.rp];
  assign count     = s_q.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (flush) begin
      s_d = '0;
    end else begin
      if (push) s_d.wp = s_q.wp + AW'(1);
      if (pop) s_d.rp = s_q.rp + AW'(1);
      s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) s_q <= '0;
    else s_q <= s_d;
  end

  always_ff @(posedge pclk) begin
    if (push && !flush) mem[s_q.wp] <= in_data;
  end
endmodule : tcs_fifo
`default_nettype wire

// File: logic/tcs_cond_eval.sv
// one trigger level: basic pattern or advanced expression
`default_nettype none
`include "tcs_cfg.svh"
module tcs_cond_eval
  import tcs_pkg::*;
(
  input  wire tcs_pkg::tcs_word_t cur,
  input  wire tcs_pkg::tcs_word_t prev,
  input  wire logic               adv_sel,
  input  wire tcs_pkg::tcs_word_t mask,
  input  wire tcs_pkg::tcs_word_t value,
  input  wire tcs_pkg::tcs_word_t edge_en,
  input  wire logic [31:0]        adv,
  input  wire tcs_pkg::tcs_word_t cst,
  output logic                    hit
);
  import tcs_pkg::*;
  tcs_word_t rise, fall, bmatch, opa, sh;
  logic cmp_t, red_t, edge_t;

  assign rise = cur & ~prev;
  assign fall = ~cur & prev;

  // per bit: mask=0 ignore; edge_en=0 level match value; edge_en=1 value
  // selects rise (value 1) or fall (value 0); no any-edge setting per bit
  // five per-signal conditions
  always_comb begin
    for (int i = 0; i < `TCS_PROBE_W; i++) begin
      if (!mask[i]) bmatch[i] = 1'b1;
      else if (!edge_en[i]) bmatch[i] = (cur[i] == value[i]);
      else bmatch[i] = value[i] ? rise[i] : fall[i];
    end
  end

  always_comb begin
    unique case (adv[`TCS_ADV_BW_HI:`TCS_ADV_BW_LO])
      2'h0: opa = cur;
      2'h1: opa = ~cur;
      2'h2: opa = cur & mask;
      default: opa = cur ^ mask;
    endcase
    if (adv[`TCS_ADV_SHL]) sh = opa << adv[`TCS_ADV_SH_HI:`TCS_ADV_SH_LO];
    else sh = opa >> adv[`TCS_ADV_SH_HI:`TCS_ADV_SH_LO];
  end

  always_comb begin
    unique case (adv[`TCS_ADV_CMP_HI:`TCS_ADV_CMP_LO])
      TCS_CMP_LT: cmp_t = sh < cst;
      TCS_CMP_LE: cmp_t = sh <= cst;
      TCS_CMP_EQ: cmp_t = sh == cst;
      TCS_CMP_NE: cmp_t = sh != cst;
      TCS_CMP_GT: cmp_t = sh > cst;
      TCS_CMP_GE: cmp_t = sh >= cst;
      default:    cmp_t = 1'b0;
    endcase
  end

  always_comb begin
    unique case (adv[`TCS_ADV_RED_HI:`TCS_ADV_RED_LO])
      2'h0: red_t = &sh;
      2'h1: red_t = |sh;
      2'h2: red_t = ^sh;
      default: red_t = 1'b1;
    endcase
  end

  always_comb begin
    logic [4:0] b;
    b = adv[`TCS_ADV_EDGE_HI:`TCS_ADV_EDGE_LO];
    unique case (adv[`TCS_ADV_ESEL_HI:`TCS_ADV_ESEL_LO])
      3'h0: edge_t = 1'b1;
      3'h1: edge_t = ~cur[b];
      3'h2: edge_t = cur[b];
      3'h3: edge_t = fall[b];
      3'h4: edge_t = rise[b];
      3'h5: edge_t = rise[b] | fall[b];
      default: edge_t = 1'b0;
    endcase
  end

  always_comb begin
    logic t;
    t = 1'b0;
    unique case (adv[`TCS_ADV_LOG_HI:`TCS_ADV_LOG_LO])
      2'h0: t = cmp_t && red_t && edge_t;
      2'h1: t = cmp_t || red_t || edge_t;
      2'h2: t = (cmp_t ^ red_t) && edge_t;
      default: t = cmp_t && edge_t;
    endcase
    // basic is AND of all signals
    if (adv_sel) hit = adv[`TCS_ADV_NOT] ? !t : t;
    else hit = &bmatch;
  end
endmodule : tcs_cond_eval
`default_nettype wire

// File: logic/tcs_trigger_seq.sv
// trigger condition sequencer with apb registers and capture fifo
//
// Functional notes
// - sample continuously until trigger, then stop
// - per-signal ignore/low/high/fall/rise/any (basic mode has no any-edge: edge_en=1 gives rise or fall only)
// - masked bus bits never affect basic match
// - basic condition is AND of signals
// - six magnitude/equality comparisons
// - logical, reduction, shift and bitwise operators
// - level/edge detector as boolean term
// - sequential default, up to ten levels
// - levels in order; final one triggers
// - later segments trigger on last level
// - external trigger is level zero first
// - works segmented and non-segmented
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`default_nettype none
`include "tcs_cfg.svh"
module tcs_trigger_seq
  import tcs_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire tcs_pkg::tcs_word_t probe,
  input  wire logic               ext_trig,
  output logic                    triggered,
  output logic                    armed
);
  import tcs_pkg::*;

  typedef struct packed {
    logic [31:0]          ctrl;
    logic [`TCS_LVL_W-1:0] lsel;
    logic [`TCS_LEVELS-1:0] adv_sel;
    logic [31:0]          rdata;
    logic                 rdy;
    logic                 err;
    tcs_state_t           st;
    logic [`TCS_LVL_W-1:0] lvl;
    logic [`TCS_SEG_W-1:0] seg;
    logic                 trig;
    logic                 pop;
    tcs_word_t            p1;
    tcs_word_t            p2;
    tcs_word_t            prev;
    logic                 e1;
    logic                 e2;
    logic                 arm;
  } tcs_top_st_t;

  tcs_top_st_t s_q, s_d;

  // per-level configuration arrays
  tcs_word_t   mask_q  [`TCS_LEVELS];
  tcs_word_t   value_q [`TCS_LEVELS];
  tcs_word_t   edge_q  [`TCS_LEVELS];
  tcs_word_t   cst_q   [`TCS_LEVELS];
  logic [31:0] adv_q   [`TCS_LEVELS];
  logic [`TCS_LEVELS-1:0] hit;

  tcs_stream_if cap ();
  logic [$clog2(`TCS_FIFO_DEPTH):0] fcnt;
  logic      rd_valid;
  tcs_word_t rd_data;
  logic      setup_w, acc;
  logic [`TCS_LVL_W-1:0] last_lvl;

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction : addr_is

  // one evaluator per level, every clock
  genvar g;
  generate
    for (g = 0; g < `TCS_LEVELS; g++) begin : g_lvl
      tcs_cond_eval u_eval (
        .cur     (s_q.p2),
        .prev    (s_q.prev),
        .adv_sel (s_q.adv_sel[g]),
        .mask    (mask_q[g]),
        .value   (value_q[g]),
        .edge_en (edge_q[g]),
        .adv     (adv_q[g]),
        .cst     (cst_q[g]),
        .hit     (hit[g])
      );
    end
  endgenerate

  // capture stream: fifo holds the newest samples, oldest dropped while armed
  assign cap.valid = (s_q.st == TCS_ST_EXT) || (s_q.st == TCS_ST_SEQ);
  assign cap.data  = s_q.p2;

  tcs_fifo #(.WIDTH(`TCS_PROBE_W), .DEPTH(`TCS_FIFO_DEPTH)) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .flush     (setup_w && addr_is(paddr, `TCS_OFF_CTRL) && pwdata[`TCS_CTRL_ARM]),
    .in_valid  (cap.valid),
    .in_ready  (cap.ready),
    .in_data   (cap.data),
    .out_valid (rd_valid),
    .out_ready (s_q.pop || (cap.valid &&
                fcnt == ($clog2(`TCS_FIFO_DEPTH)+1)'(`TCS_FIFO_DEPTH))),
    .out_data  (rd_data),
    .count     (fcnt)
  );

  assign acc     = psel && penable && !s_q.rdy;
  assign setup_w = acc && pwrite;
  assign last_lvl = (s_q.ctrl[`TCS_CTRL_NLVL_HI:`TCS_CTRL_NLVL_LO] == '0) ? '0 :
    s_q.ctrl[`TCS_CTRL_NLVL_HI:`TCS_CTRL_NLVL_LO] - `TCS_LVL_W'(1);

  always_comb begin
    s_d = s_q;
    s_d.rdy = 1'b0;
    s_d.err = 1'b0;
    s_d.pop = 1'b0;
    // two-flop sync of monitored logic and external trigger
    s_d.p1 = probe;
    s_d.p2 = s_q.p1;
    s_d.prev = s_q.p2;
    s_d.e1 = ext_trig;
    s_d.e2 = s_q.e1;

    unique case (s_q.st)
      TCS_ST_IDLE: begin
      end
      TCS_ST_EXT: begin
        if (s_q.e2) s_d.st = TCS_ST_SEQ;
      end
      TCS_ST_SEQ: begin
        if (hit[s_q.lvl]) begin
          if (s_q.lvl >= last_lvl) begin
            s_d.trig = 1'b1;
            s_d.st = TCS_ST_DONE;
            // next segment uses last level only
            if (s_q.ctrl[`TCS_CTRL_SEG_EN] &&
                s_q.seg < s_q.ctrl[`TCS_CTRL_NSEG_HI:`TCS_CTRL_NSEG_LO]) begin
              s_d.seg = s_q.seg + `TCS_SEG_W'(1);
              s_d.st = TCS_ST_SEQ;
              s_d.lvl = last_lvl;
            end
          end else begin
            s_d.lvl = s_q.lvl + `TCS_LVL_W'(1);
          end
        end
      end
      TCS_ST_DONE: begin
      end
    endcase

    if (acc) begin
      s_d.rdy = 1'b1;
      s_d.rdata = '0;
      if (pwrite) begin
        if (addr_is(paddr, `TCS_OFF_CTRL)) begin
          s_d.ctrl = pwdata;
          s_d.ctrl[`TCS_CTRL_ARM] = 1'b0;
          if (pwdata[`TCS_CTRL_ARM]) begin
            // sequential flow restarts at level 0
            s_d.st = pwdata[`TCS_CTRL_EXT_EN] ? TCS_ST_EXT : TCS_ST_SEQ;
            s_d.lvl = '0;
            s_d.seg = '0;
            s_d.trig = 1'b0;
          end
        end else if (addr_is(paddr, `TCS_OFF_LSEL)) begin
          s_d.lsel = pwdata[`TCS_LVL_W-1:0];
        end else if (addr_is(paddr, `TCS_OFF_COND)) begin
          s_d.adv_sel[s_q.lsel] = pwdata[`TCS_COND_ADV];
        end else if (!(addr_is(paddr, `TCS_OFF_MASK) || addr_is(paddr, `TCS_OFF_VALUE) ||
                       addr_is(paddr, `TCS_OFF_EDGE) || addr_is(paddr, `TCS_OFF_ADV) ||
                       addr_is(paddr, `TCS_OFF_CONST))) begin
          s_d.err = 1'b1;
        end
      end else begin
        if (addr_is(paddr, `TCS_OFF_CTRL)) s_d.rdata = s_q.ctrl;
        else if (addr_is(paddr, `TCS_OFF_STATUS))
          s_d.rdata = {20'h0_0000, s_q.seg, s_q.lvl, 1'b0, s_q.trig, s_q.st};
        else if (addr_is(paddr, `TCS_OFF_LSEL)) s_d.rdata = 32'(s_q.lsel);
        else if (addr_is(paddr, `TCS_OFF_COND)) s_d.rdata = 32'(s_q.adv_sel[s_q.lsel]);
        else if (addr_is(paddr, `TCS_OFF_SAMPLES)) s_d.rdata = 32'(fcnt);
        else if (addr_is(paddr, `TCS_OFF_DATA)) begin
          // stored samples only readable once stopped
          if (s_q.st == TCS_ST_DONE && rd_valid) begin
            s_d.rdata = rd_data;
            s_d.pop = 1'b1;
          end
        end else if (!(addr_is(paddr, `TCS_OFF_MASK) || addr_is(paddr, `TCS_OFF_VALUE) ||
                       addr_is(paddr, `TCS_OFF_EDGE) || addr_is(paddr, `TCS_OFF_ADV) ||
                       addr_is(paddr, `TCS_OFF_CONST))) begin
          s_d.err = 1'b1;
        end else if (addr_is(paddr, `TCS_OFF_MASK)) s_d.rdata = mask_q[s_q.lsel];
        else if (addr_is(paddr, `TCS_OFF_VALUE)) s_d.rdata = value_q[s_q.lsel];
        else if (addr_is(paddr, `TCS_OFF_EDGE)) s_d.rdata = edge_q[s_q.lsel];
        else if (addr_is(paddr, `TCS_OFF_ADV)) s_d.rdata = adv_q[s_q.lsel];
        else s_d.rdata = cst_q[s_q.lsel];
      end
    end
    // armed output straight from a flop
    s_d.arm = (s_d.st == TCS_ST_EXT) || (s_d.st == TCS_ST_SEQ);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.ctrl <= `TCS_CTRL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // per-level pattern storage, written through lsel window
  always_ff @(posedge pclk) begin
    if (setup_w && s_q.lsel < `TCS_LVL_W'(`TCS_LEVELS)) begin
      if (addr_is(paddr, `TCS_OFF_MASK)) mask_q[s_q.lsel] <= pwdata;
      if (addr_is(paddr, `TCS_OFF_VALUE)) value_q[s_q.lsel] <= pwdata;
      if (addr_is(paddr, `TCS_OFF_EDGE)) edge_q[s_q.lsel] <= pwdata;
      if (addr_is(paddr, `TCS_OFF_ADV)) adv_q[s_q.lsel] <= pwdata;
      if (addr_is(paddr, `TCS_OFF_CONST)) cst_q[s_q.lsel] <= pwdata;
    end
  end

  assign prdata    = s_q.rdata;
  assign pready    = s_q.rdy;
  assign pslverr   = s_q.err;
  assign triggered = s_q.trig;
  assign armed     = s_q.arm;
endmodule : tcs_trigger_seq
`default_nettype wire

// File: tb/tcs_trigger_seq_chk.sv
// port assertions of the trigger condition sequencer
`default_nettype none
module tcs_trigger_seq_chk (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire tcs_pkg::tcs_word_t probe,
  input wire logic               ext_trig,
  input wire logic               triggered,
  input wire logic               armed
);
  import tcs_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic acc;
  logic armw;
  logic ext_on_q;
  logic ext_seen_q;
  assign acc  = psel && penable;
  assign armw = acc && pwrite && paddr == 12'h000 && pwdata[0];
  // raw pin seen earlier than the synced copy, so this errs on the lenient side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_on_q   <= 1'b0;
      ext_seen_q <= 1'b0;
    end else if (armw) begin
      ext_on_q   <= pwdata[1];
      ext_seen_q <= 1'b0;
    end else if (ext_trig) begin
      ext_seen_q <= 1'b1;
    end
  end
  a_ready_next: assert property (acc && !pready |=> pready)
    else $error("access not answered after one wait cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_cause: assert property (pready |-> $past(acc))
    else $error("pready without access");
  a_err_unmapped: assert property (pready && (paddr > 12'h028 || paddr[1:0] != 2'b00) |-> pslverr)
    else $error("unmapped access without error");
  a_err_mapped: assert property (pready && paddr <= 12'h028 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access flagged");
  a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_data_early: assert property (
    pready && !pwrite && paddr == 12'h028 && !triggered && $past(!triggered)
    |-> prdata == 32'h0000_0000) else $error("sample data before trigger");
  a_trig_holds: assert property (triggered && !armw && !$past(armw) |=> triggered)
    else $error("triggered dropped without arm");
  a_arm_starts: assert property (armw && !pready |-> ##[1:4] (armed && !triggered))
    else $error("arm did not start acquisition");
  // trigger only from an armed sequence
  a_trig_armed: assert property ($rose(triggered) |-> $past(armed))
    else $error("trigger while not armed");
  a_ext_first: assert property ($rose(triggered) && ext_on_q |-> ext_seen_q)
    else $error("trigger before external level");
  c_trig: cover property ($rose(triggered));
  c_ext: cover property ($rose(triggered) && ext_on_q);
  c_err: cover property (pready && pslverr);
endmodule : tcs_trigger_seq_chk

bind tcs_trigger_seq tcs_trigger_seq_chk i_tcs_trigger_seq_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .probe, .ext_trig, .triggered, .armed
);
`default_nettype wire

// File: tb/tcs_probe_model.sv
// behavioural model of the monitored user logic
`default_nettype none
module tcs_probe_model (
  input  wire logic               pclk,
  input  wire tcs_pkg::tcs_word_t probe_nxt,
  input  wire logic               ext_nxt,
  output tcs_pkg::tcs_word_t      probe,
  output logic                    ext_trig
);
  timeunit 1ns;
  timeprecision 1ps;
  import tcs_pkg::*;
  // user logic is synchronous, values move only after an edge
  initial begin
    probe    = 32'h0000_0000;
    ext_trig = 1'b0;
  end
  always @(posedge pclk) begin
    probe    <= probe_nxt;
    ext_trig <= ext_nxt;
  end
endmodule : tcs_probe_model
`default_nettype wire

// File: tb/tb.sv
// self-checking bench of the trigger condition sequencer
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tcs_pkg::*;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic        ext_nxt = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  tcs_word_t   pnxt    = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, triggered, armed, ext_trig, err;
  tcs_word_t   probe;
  tcs_word_t   hist[$];
  int          error_cnt   = 0;
  int          checks_done = 0;
  // cond, mask, value, edge, adv; then {e0, s0, s1, s2} levels of bit 3
  localparam logic [31:0] BT [6][5] = '{'{0, 0, 0, 0, 0}, '{0, 8, 0, 0, 0},
    '{0, 8, 8, 0, 0}, '{0, 8, 0, 8, 0}, '{0, 8, 8, 8, 0}, '{1, 8, 0, 0, 32'h00a3_001d}};
  localparam logic [3:0] BS [6] = '{4'b1000, 4'b0110, 4'b0001, 4'b0010, 4'b0101, 4'b0110};

  always #2 pclk = ~pclk;
  always @(posedge pclk) hist.push_back(probe);

  tcs_trigger_seq i_tcs_trigger_seq (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .probe, .ext_trig, .triggered, .armed);
  tcs_probe_model i_tcs_probe_model (.pclk, .probe_nxt(pnxt), .ext_nxt, .probe, .ext_trig);

  task automatic results;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : cmp

  task automatic trig_is(input logic e);
    cmp({31'h0, triggered}, {31'h0, e});
  endtask : trig_is

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) error_cnt++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic hold(input int n, input tcs_word_t v);
    pnxt <= v;
    repeat (n) @(posedge pclk);
  endtask : hold

  task automatic lvl(input logic [31:0] i, c, m, v, e, a, k);
    apb(1, 12'h008, i);
    apb(1, 12'h00c, c);
    apb(1, 12'h010, m);
    apb(1, 12'h014, v);
    apb(1, 12'h018, e);
    apb(1, 12'h01c, a);
    apb(1, 12'h020, k);
  endtask : lvl

  // probe held across arm so no stray edge is seen
  task automatic adv_try(input logic [31:0] a, m, k, p, input logic e);
    lvl(0, 32'h1, m, 0, 0, a, k);
    hold(10, p);
    apb(1, 12'h000, 32'h0000_0011);
    hold(10, p);
    trig_is(e);
  endtask : adv_try

  function automatic logic rel(input int op, input tcs_word_t p, input tcs_word_t k);
    case (op)
      0: return p < k;
      1: return p <= k;
      2: return p == k;
      3: return p != k;
      4: return p > k;
      default: return p >= k;
    endcase
  endfunction : rel

  initial begin
    #100_000;
    error_cnt++;
    results();
  end

  initial begin
    tcs_word_t v;
    tcs_word_t w;
    tcs_word_t q[8];
    int i;
    void'($urandom(32'h390f_1be2));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 12'h000, 0);
    cmp(rd, 32'h0000_0010);
    apb(0, 12'h030, 0);
    cmp({rd[30:0], err}, 32'h0000_0001);
    lvl(0, 0, 32'h0000_ff00, 32'h0000_ab00, 0, 0, 0);
    apb(1, 12'h000, 32'h0000_0011);
    hist.delete();
    apb(0, 12'h028, 0);
    cmp(rd, 32'h0000_0000);
    repeat (30) begin
      v = $urandom;
      if (v[15:8] == 8'hab) v[8] = 1'b0;
      hold(1, v);
    end
    trig_is(1'b0);
    v = $urandom;
    v[15:8] = 8'hab;
    hold(12, v);
    trig_is(1'b1);
    cmp({31'h0, armed}, 32'h0);
    apb(0, 12'h024, 0);
    cmp(rd, 32'h0000_0008);
    for (int k = 0; k < 8; k++) begin
      apb(0, 12'h028, 0);
      q[k] = rd;
    end
    cmp(q[7], v);
    i = 0;
    foreach (hist[j]) if (hist[j] === q[0]) i = j;
    for (int k = 1; k < 8; k++) cmp(q[k], hist[i + k]);
    foreach (BS[r]) begin
      lvl(0, BT[r][0], BT[r][1], BT[r][2], BT[r][3], BT[r][4], 0);
      for (int s = 2; s >= 0; s--) begin
        v = $urandom;
        v[3] = BS[r][s];
        hold(10, v);
        if (s == 2) begin
          apb(1, 12'h000, 32'h0000_0011);
          hold(10, v);
        end
        trig_is(s == 0 || BS[r][3]);
      end
    end
    for (int op = 0; op < 6; op++) begin
      for (int d = -1; d < 2; d++) begin
        v = ($urandom >> 1) | 32'h0000_0100;
        adv_try(32'h0000_0018 | op, '1, v, v + d, rel(op, v + d, v));
      end
    end
    v = $urandom;
    w = $urandom | 32'h0000_0001;
    adv_try(32'h0000_007a, w, v, v ^ w, 1'b1);
    adv_try(32'h0000_007a, w, v, v, 1'b0);
    adv_try(32'h0000_049a, '1, v << 4, v, 1'b1);
    adv_try(32'h0000_041a, '1, v >> 4, v, 1'b1);
    adv_try(32'h0000_801a, '1, v, v, 1'b0);
    for (int l = 0; l < 10; l++) lvl(l, 0, 32'h0000_00ff, l + 1, 0, 0, 0);
    hold(1, 0);
    apb(1, 12'h000, 32'h0000_00a3);
    for (int l = 1; l < 11; l++) hold(6, l);
    trig_is(1'b0);
    apb(0, 12'h004, 0);
    cmp({30'h0, rd[1:0]}, 32'h0000_0001);
    ext_nxt <= 1'b1;
    hold(6, 10);
    ext_nxt <= 1'b0;
    for (int l = 1; l < 10; l++) hold(6, l);
    trig_is(1'b0);
    hold(10, 10);
    trig_is(1'b1);
    hold(1, 0);
    apb(1, 12'h000, 32'h0000_0125);
    hold(6, 1);
    hold(1, 2);
    hold(10, 0);
    cmp({30'h0, triggered, armed}, 32'h0000_0003);
    hold(1, 2);
    hold(10, 0);
    cmp({30'h0, triggered, armed}, 32'h0000_0002);
    results();
  end
endmodule : tb
`default_nettype wire
